// ---- rtl/pwmdb_pkg.sv ----
// constants for the three-unit pulse-width generator with dead-band stage
package pwmdb_pkg;

    localparam int unsigned NUM_UNITS = 3;
    localparam int unsigned CNT_W     = 16;
    localparam int unsigned NUM_OUTS  = 2 * NUM_UNITS;

    // register index = addr[7:4] unit, addr[3:0] register
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_LOAD     = 8'h01;
    localparam logic [7:0] REG_CMPA     = 8'h02;
    localparam logic [7:0] REG_CMPB     = 8'h03;
    localparam logic [7:0] REG_ACT_A    = 8'h04;
    localparam logic [7:0] REG_ACT_B    = 8'h05;
    localparam logic [7:0] REG_DB_RISE  = 8'h06;
    localparam logic [7:0] REG_DB_FALL  = 8'h07;
    localparam logic [7:0] REG_COUNT    = 8'h08;
    localparam logic [7:0] REG_OUT_EN   = 8'hf0;
    localparam logic [7:0] REG_OUT_INV  = 8'hf1;
    localparam logic [7:0] REG_STATUS   = 8'hf2;

    // control register fields
    localparam int unsigned CTRL_RUN    = 0;
    localparam int unsigned CTRL_UPDOWN = 1;
    localparam int unsigned CTRL_DB_EN  = 2;

    // action field positions within an action register
    localparam int unsigned ACT_ZERO  = 0;
    localparam int unsigned ACT_LOAD  = 2;
    localparam int unsigned ACT_A_UP  = 4;
    localparam int unsigned ACT_A_DN  = 6;
    localparam int unsigned ACT_B_UP  = 8;
    localparam int unsigned ACT_B_DN  = 10;

    localparam logic [1:0] ACT_NONE   = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_LOW    = 2'h2;
    localparam logic [1:0] ACT_HIGH   = 2'h3;

    localparam logic [15:0] RST_VALUE = 16'h0000;

endpackage

// ---- rtl/pwmdb_top.sv ----
// three pulse-width generator units with dead-band stage and output control
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module pwmdb_top #(
    parameter int unsigned UNITS = pwmdb_pkg::NUM_UNITS,
    parameter int unsigned CW    = pwmdb_pkg::CNT_W
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // register port
    input  wire logic [7:0]        reg_addr,
    input  wire logic [15:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [15:0]       reg_rdata,
    // pins
    output logic      [2*UNITS-1:0] pwm_pin
);

    localparam int unsigned NO = 2 * UNITS;

    // software state: per-unit registers, then the shared pin enable and invert
    logic [2:0]    ctrl        [UNITS];
    logic [CW-1:0] load_value  [UNITS];
    logic [CW-1:0] cmp_a_value [UNITS];
    logic [CW-1:0] compare_b_value [UNITS];
    logic [11:0]   act_a       [UNITS];
    logic [11:0]   act_b       [UNITS];
    logic [CW-1:0] db_rise     [UNITS];
    logic [CW-1:0] db_fall     [UNITS];
    logic [NO-1:0] out_en;
    logic [NO-1:0] out_inv;

    // per-unit datapath state
    logic [CW-1:0] count       [UNITS];
    logic          dir_up      [UNITS];
    logic          first_wave_output  [UNITS];
    logic          second_wave_output [UNITS];
    logic [CW-1:0] db_cnt_hi   [UNITS];
    logic [CW-1:0] db_cnt_lo   [UNITS];
    logic          db_hi       [UNITS];
    logic          db_lo       [UNITS];
    logic [NO-1:0] raw_out;

    function automatic logic apply_act(input logic cur, input logic [1:0] act);
        logic r;
        r = cur;
        unique case (act)
            pwmdb_pkg::ACT_NONE:   r = cur;
            pwmdb_pkg::ACT_TOGGLE: r = ~cur;
            pwmdb_pkg::ACT_LOW:    r = 1'b0;
            pwmdb_pkg::ACT_HIGH:   r = 1'b1;
        endcase
        return r;
    endfunction

    // one generator output through its four events, matches losing to zero/load
    function automatic logic gen_step(input logic cur, input logic [11:0] act,
                                      input logic zero, input logic ld,
                                      input logic up_m, input logic dn_m,
                                      input logic use_a);
        logic r;
        r = cur;
        if (zero) begin
            r = apply_act(r, act[pwmdb_pkg::ACT_ZERO +: 2]);
        end
        if (ld) begin
            r = apply_act(r, act[pwmdb_pkg::ACT_LOAD +: 2]);
        end
        if (!zero && !ld) begin
            if (up_m) begin
                r = apply_act(r, use_a ? act[pwmdb_pkg::ACT_A_UP +: 2]
                                       : act[pwmdb_pkg::ACT_B_UP +: 2]);
            end
            if (dn_m) begin
                r = apply_act(r, use_a ? act[pwmdb_pkg::ACT_A_DN +: 2]
                                       : act[pwmdb_pkg::ACT_B_DN +: 2]);
            end
        end
        return r;
    endfunction

    // register writes
    always_ff @(posedge clk) begin
        if (rst) begin
            out_en  <= '0;
            out_inv <= '0;
        end else if (reg_wr && reg_addr == pwmdb_pkg::REG_OUT_EN) begin
            out_en <= reg_wdata[NO-1:0];
        end else if (reg_wr && reg_addr == pwmdb_pkg::REG_OUT_INV) begin
            out_inv <= reg_wdata[NO-1:0];
        end
    end

    for (genvar u = 0; u < UNITS; u++) begin : g_unit
        logic       zero_s;
        logic       load_s;
        logic       a_hit;
        logic       b_hit;
        logic       a_up;
        logic       a_dn;
        logic       b_up;
        logic       b_dn;
        logic [3:0] sel;

        assign sel = 4'(u);

        always_ff @(posedge clk) begin
            if (rst) begin
                ctrl[u]            <= '0;
                load_value[u]      <= pwmdb_pkg::RST_VALUE;
                cmp_a_value[u]     <= pwmdb_pkg::RST_VALUE;
                compare_b_value[u] <= pwmdb_pkg::RST_VALUE;
                act_a[u]           <= '0;
                act_b[u]           <= '0;
                db_rise[u]         <= pwmdb_pkg::RST_VALUE;
                db_fall[u]         <= pwmdb_pkg::RST_VALUE;
            end else if (reg_wr && reg_addr[7:4] == sel) begin
                unique case ({4'h0, reg_addr[3:0]})
                    pwmdb_pkg::REG_CTRL:    ctrl[u]            <= reg_wdata[2:0];
                    pwmdb_pkg::REG_LOAD:    load_value[u]      <= reg_wdata;
                    pwmdb_pkg::REG_CMPA:    cmp_a_value[u]     <= reg_wdata;
                    pwmdb_pkg::REG_CMPB:    compare_b_value[u] <= reg_wdata;
                    pwmdb_pkg::REG_ACT_A:   act_a[u]           <= reg_wdata[11:0];
                    pwmdb_pkg::REG_ACT_B:   act_b[u]           <= reg_wdata[11:0];
                    pwmdb_pkg::REG_DB_RISE: db_rise[u]         <= reg_wdata;
                    pwmdb_pkg::REG_DB_FALL: db_fall[u]         <= reg_wdata;
                    default: ;
                endcase
            end
        end

        // strobes decoded from the counter value, one clock each while load_value is nonzero
        assign zero_s = ctrl[u][pwmdb_pkg::CTRL_RUN] && count[u] == '0;
        assign load_s = ctrl[u][pwmdb_pkg::CTRL_RUN] && count[u] == load_value[u];
        // the count can still pass a value above a freshly lowered load, so gate it
        assign a_hit  = ctrl[u][pwmdb_pkg::CTRL_RUN] && count[u] == cmp_a_value[u]
                        && cmp_a_value[u] <= load_value[u];
        assign b_hit  = ctrl[u][pwmdb_pkg::CTRL_RUN] && count[u] == compare_b_value[u]
                        && compare_b_value[u] <= load_value[u];
        // direction qualifies matches; down mode has only down matches
        assign a_up   = a_hit && dir_up[u];
        assign a_dn   = a_hit && !dir_up[u];
        assign b_up   = b_hit && dir_up[u];
        assign b_dn   = b_hit && !dir_up[u];

        // counter
        always_ff @(posedge clk) begin
            if (rst) begin
                count[u]  <= '0;
                dir_up[u] <= 1'b0;
            end else if (!ctrl[u][pwmdb_pkg::CTRL_RUN]) begin
                count[u]  <= '0;
                dir_up[u] <= 1'b0;
            end else if (!ctrl[u][pwmdb_pkg::CTRL_UPDOWN]) begin
                // zero at n, load at n+1
                dir_up[u] <= 1'b0;
                count[u]  <= (count[u] == '0) ? load_value[u] : count[u] - 1'b1;
            end else begin
                if (count[u] == '0 && load_value[u] != '0) begin
                    dir_up[u] <= 1'b1;
                    count[u]  <= count[u] + 1'b1;
                end else if (count[u] >= load_value[u]) begin
                    dir_up[u] <= 1'b0;
                    count[u]  <= (count[u] == '0) ? '0 : count[u] - 1'b1;
                end else if (dir_up[u]) begin
                    count[u] <= count[u] + 1'b1;
                end else begin
                    count[u] <= count[u] - 1'b1;
                end
            end
        end

        // waveform generator; A drives first output, B second
        always_ff @(posedge clk) begin
            if (rst || !ctrl[u][pwmdb_pkg::CTRL_RUN]) begin
                first_wave_output[u]  <= 1'b0;
                second_wave_output[u] <= 1'b0;
            end else begin
                first_wave_output[u]  <= gen_step(first_wave_output[u], act_a[u],
                                                  zero_s, load_s, a_up, a_dn, 1'b1);
                second_wave_output[u] <= gen_step(second_wave_output[u], act_b[u],
                                                  zero_s, load_s, b_up, b_dn, 1'b0);
            end
        end

        // dead-band: each output rises only after its delay count has run
        always_ff @(posedge clk) begin
            if (rst) begin
                db_hi[u]     <= 1'b0;
                db_lo[u]     <= 1'b0;
                db_cnt_hi[u] <= '0;
                db_cnt_lo[u] <= '0;
            end else begin
                if (!first_wave_output[u]) begin
                    db_hi[u]     <= 1'b0;
                    db_cnt_hi[u] <= '0;
                end else if (db_cnt_hi[u] >= db_rise[u]) begin
                    db_hi[u] <= 1'b1;
                end else begin
                    db_cnt_hi[u] <= db_cnt_hi[u] + 1'b1;
                end
                if (first_wave_output[u]) begin
                    db_lo[u]     <= 1'b0;
                    db_cnt_lo[u] <= '0;
                end else if (db_cnt_lo[u] >= db_fall[u]) begin
                    db_lo[u] <= 1'b1;
                end else begin
                    db_cnt_lo[u] <= db_cnt_lo[u] + 1'b1;
                end
            end
        end

        // with dead-band on, each side falls at once with the input, so they can never overlap; with it off, A and B drive the pair directly
        assign raw_out[2*u]   = ctrl[u][pwmdb_pkg::CTRL_DB_EN] ? db_hi[u] & first_wave_output[u]
                                                               : first_wave_output[u];
        assign raw_out[2*u+1] = ctrl[u][pwmdb_pkg::CTRL_DB_EN] ? db_lo[u] & ~first_wave_output[u]
                                                               : second_wave_output[u];
    end

    // output control: disabled pins sit at their inactive level
    always_ff @(posedge clk) begin
        if (rst) begin
            pwm_pin <= '0;
        end else begin
            pwm_pin <= (raw_out & out_en) ^ out_inv;
        end
    end

    // read data, one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk) begin
        if (rst || !reg_rd) begin
            reg_rdata <= '0;
        end else if (reg_addr == pwmdb_pkg::REG_OUT_EN) begin
            reg_rdata <= 16'(out_en);
        end else if (reg_addr == pwmdb_pkg::REG_OUT_INV) begin
            reg_rdata <= 16'(out_inv);
        end else if (reg_addr == pwmdb_pkg::REG_STATUS) begin
            reg_rdata <= 16'(raw_out);
        end else begin
            reg_rdata <= '0;
            for (int i = 0; i < UNITS; i++) begin
                if (reg_addr[7:4] == 4'(i)) begin
                    unique case ({4'h0, reg_addr[3:0]})
                        pwmdb_pkg::REG_CTRL:    reg_rdata <= {13'h0000, ctrl[i]};
                        pwmdb_pkg::REG_LOAD:    reg_rdata <= load_value[i];
                        pwmdb_pkg::REG_CMPA:    reg_rdata <= cmp_a_value[i];
                        pwmdb_pkg::REG_CMPB:    reg_rdata <= compare_b_value[i];
                        pwmdb_pkg::REG_ACT_A:   reg_rdata <= {4'h0, act_a[i]};
                        pwmdb_pkg::REG_ACT_B:   reg_rdata <= {4'h0, act_b[i]};
                        pwmdb_pkg::REG_DB_RISE: reg_rdata <= db_rise[i];
                        pwmdb_pkg::REG_DB_FALL: reg_rdata <= db_fall[i];
                        pwmdb_pkg::REG_COUNT:   reg_rdata <= {dir_up[i], 15'h0000} | count[i];
                        default:                reg_rdata <= '0;
                    endcase
                end
            end
        end
    end

endmodule
`default_nettype wire

// ---- tb/pwmdb_checker.sv ----
// port assertions for the pulse-width generator block
`timescale 1ns/10ps
`default_nettype none
module pwmdb_checker #(
    parameter int unsigned UNITS = 3
) (
    // clock and reset
    input wire logic                 clk,
    input wire logic                 rst,
    // register port
    input wire logic [7:0]           reg_addr,
    input wire logic [15:0]          reg_wdata,
    input wire logic                 reg_wr,
    input wire logic                 reg_rd,
    input wire logic [15:0]          reg_rdata,
    // pins
    input wire logic [2*UNITS-1:0]   pwm_pin
);
    logic [15:0] sh [0:255];
    logic [7:0]  since_wr;
    logic        rd_q;
    wire         cnt_rd = reg_rd && reg_addr == 8'h08;
    wire  [15:0] ctl0   = sh[8'h00];
    wire  [15:0] ld0    = sh[8'h01];
    wire  [15:0] en     = sh[8'hf0];
    wire  [15:0] inv    = sh[8'hf1];
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // shadow of everything written, mapped or not
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 256; i++) sh[i] <= 16'h0000;
        end else if (reg_wr) begin
            sh[reg_addr] <= reg_wdata;
        end
    end
    // settle time after any write, since pins lag registers
    always_ff @(posedge clk) begin
        if (rst || reg_wr) since_wr <= 8'h00;
        else if (since_wr != 8'hff) since_wr <= since_wr + 8'h01;
    end
    always_ff @(posedge clk) begin
        rd_q <= cnt_rd && !rst;
    end
    AST_DOWN_STEP: assert property (cnt_rd && rd_q && ctl0[1:0] == 2'b01 |=>
        reg_rdata == $past(reg_rdata) - 16'h1 || ($past(reg_rdata) == 16'h0 && reg_rdata == ld0))
        else $error("down count step wrong");
    AST_DOWN_DIR: assert property (cnt_rd && ctl0[1:0] == 2'b01 && !ld0[15] |=>
        reg_rdata < 16'h8000) else $error("direction high in down mode");
    AST_UD_UP: assert property (cnt_rd && rd_q && ctl0[1:0] == 2'b11 |=>
        $past(reg_rdata) < 16'h8000 || reg_rdata < 16'h8000
        || reg_rdata == $past(reg_rdata) + 16'h1) else $error("up count step wrong");
    AST_UD_DN: assert property (cnt_rd && rd_q && ctl0[1:0] == 2'b11 |=>
        $past(reg_rdata) >= 16'h8000 || reg_rdata >= 16'h8000 || $past(reg_rdata) == 16'h0
        || reg_rdata == $past(reg_rdata) - 16'h1) else $error("down step in up/down wrong");
    AST_DB_EXCL: assert property (ctl0[2] && since_wr > 8'd4 && inv[1:0] == 2'b00 |->
        !(pwm_pin[0] && pwm_pin[1])) else $error("dead-band pair both high");
    AST_PIN_CTRL: assert property (since_wr > 8'd2 |->
        ((pwm_pin ^ inv[2*UNITS-1:0]) & ~en[2*UNITS-1:0]) == '0) else $error("disabled pin level");
    AST_FAR_MATCH: assert property (since_wr > 8'd4 && ctl0[0] && !ctl0[2] &&
        sh[8'h02] > ld0 && sh[8'h04][3:0] == 4'h0 |-> $stable(pwm_pin[0]))
        else $error("match beyond load acted");
    AST_ACT_READBACK: assert property (reg_wr && reg_addr == 8'h04 ##1
        reg_rd && reg_addr == 8'h04 |=> reg_rdata == $past(reg_wdata, 2))
        else $error("action register readback");
endmodule
bind pwmdb_top pwmdb_checker #(.UNITS(UNITS)) u_chk (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pwm_pin(pwm_pin));
`default_nettype wire

// ---- tb/pwmdb_gate_drv.sv ----
// gate driver model of one pin pair, measures both-low dead time
`timescale 1ns/10ps
`default_nettype none
module pwmdb_gate_drv (
    // clock
    input  wire logic clk,
    // pin pair
    input  wire logic hi,
    input  wire logic lo,
    // last dead time before each side turned on, in cycles
    output var int    gap_hi,
    output var int    gap_lo
);
    int run = 0;
    always @(posedge clk) begin
        if (!hi && !lo) begin
            run++;
        end else begin
            if (run > 0 && hi) gap_hi <= run;
            if (run > 0 && lo) gap_lo <= run;
            run = 0;
        end
    end
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the pulse-width generator block
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [5:0]  pwm_pin;
    logic [15:0] d1;
    logic [15:0] d2;
    logic [7:0]  a;
    int          err_count = 0;
    int          compares = 0;
    int          cycles = 0;
    int          model [256];
    int          gap_hi;
    int          gap_lo;
    int          rise;
    int          fall;
    always #12.5 clk = ~clk;
    pwmdb_top dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwm_pin(pwm_pin));
    pwmdb_gate_drv far (.clk(clk), .hi(pwm_pin[0]), .lo(pwm_pin[1]), .gap_hi(gap_hi),
        .gap_lo(gap_lo));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (exp !== got) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // bits that each register keeps; the rest read back as zero
    function automatic logic [15:0] reg_mask(input logic [7:0] ad);
        if (ad[7:4] == 4'hf) return 16'h003f;
        if (ad[3:0] == 4'h0) return 16'h0007;
        if (ad[3:0] == 4'h4 || ad[3:0] == 4'h5) return 16'h0fff;
        return 16'hffff;
    endfunction
    // strobe is left high; the next read task or idle drops it
    task automatic wr(input logic [7:0] ad, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        reg_addr <= ad;
        reg_wdata <= d;
        if ((ad[7:4] < 4'h3 && ad[3:0] < 4'h8) || ad == 8'hf0 || ad == 8'hf1)
            model[ad] = d & reg_mask(ad);
    endtask
    task automatic idle(input int n);
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] ad, output logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= ad;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // two back-to-back reads of unit 0 count
    task automatic rd2();
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= 8'h08;
        @(posedge clk);
        #1 d1 = reg_rdata;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d2 = reg_rdata;
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            print_verdict();
        end
    end
    initial begin
        void'($urandom(32'hd4a322af));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd(8'(i), d1);
            chk("reset value", 16'(model[i]), d1);
        end
        $display("test reset values done");
        wr(8'h01, 16'd20);
        wr(8'h00, 16'h0001);
        for (int i = 0; i < 30; i++) begin
            rd2();
            chk("count down", d1 == 16'h0 ? 16'(model[1]) : d1 - 16'h1, d2);
            chk("direction", 16'h0, d1 & 16'h8000);
        end
        $display("test down count done");
        rise = $urandom_range(1, 6);
        fall = $urandom_range(1, 6);
        wr(8'h02, 16'd10);
        wr(8'h04, 16'h0083);
        rd(8'h04, d1);
        chk("action reg", 16'(model[4]), d1);
        wr(8'h06, 16'(rise));
        wr(8'h07, 16'(fall));
        wr(8'hf0, 16'h003f);
        wr(8'h00, 16'h0005);
        idle(150);
        chk("rise gap", 16'(rise + 1), 16'(gap_hi));
        chk("fall gap", 16'(fall + 1), 16'(gap_lo));
        $display("test dead band done");
        // stop clears both outputs; load is then cut below compare A while counting from 20
        wr(8'h00, 16'h0000);
        wr(8'h02, 16'd15);
        wr(8'h03, 16'h0000);
        wr(8'h04, 16'h0050);
        wr(8'h05, 16'h00c0);
        wr(8'h00, 16'h0001);
        wr(8'h01, 16'd10);
        idle(80);
        chk("far match pin", 16'h0, {15'h0, pwm_pin[0]});
        chk("match on zero pin", 16'h0, {15'h0, pwm_pin[1]});
        $display("test far match done");
        wr(8'h01, 16'd20);
        wr(8'h00, 16'h0003);
        for (int i = 0; i < 30; i++) begin
            rd2();
            if (d1[14:0] > 15'd1 && d1[14:0] < 15'd19)
                chk("count updown", d1[15] ? d1 + 16'h1 : d1 - 16'h1, d2);
        end
        $display("test up down done");
        for (int i = 0; i < 60; i++) begin
            a = {2'b00, 2'($urandom_range(1, 3)), 4'($urandom)};
            if ($urandom_range(0, 7) == 0) a = 8'hf0 | 8'($urandom_range(0, 1));
            if ($urandom_range(0, 1) == 1) wr(a, 16'($urandom));
            else begin
                rd(a, d1);
                if (a[3:0] != 4'h8 || a[7:4] > 4'h2) chk("register", 16'(model[a]), d1);
            end
        end
        idle(4);
        $display("test random registers done");
        print_verdict();
    end
endmodule
`default_nettype wire
